// [design/cssc_defines.svh]
`ifndef CSSC_DEFINES_SVH
`define CSSC_DEFINES_SVH

`define CSSC_ADDR_W          8
`define CSSC_DATA_W          8

`define CSSC_OFS_PLL_MISC    8'h13
`define CSSC_OFS_START_HI    8'h14
`define CSSC_OFS_START_LO    8'h15
`define CSSC_OFS_CLAMP_W     8'h16
`define CSSC_OFS_BLC_CFG     8'h17
`define CSSC_OFS_DCR_CTRL    8'h18
`define CSSC_OFS_OFFSET      8'h19

`define CSSC_RST_PLL_MISC    8'h04
`define CSSC_RST_START_HI    8'h00
`define CSSC_RST_START_LO    8'h03
`define CSSC_RST_CLAMP_W     8'h10
`define CSSC_RST_BLC_CFG     8'h40
`define CSSC_RST_DCR_CTRL    8'h00
`define CSSC_RST_OFFSET      8'h00

`define CSSC_BIT_CINV_DIS    3
`define CSSC_FSEL_HI         5
`define CSSC_FSEL_LO         4
`define CSSC_BIT_BLC_DIS     0
`define CSSC_BIT_DCR_EN      0
`define CSSC_START_HI_W      5
`define CSSC_CLAMP_MIN_W     8'h02

`define CSSC_CLK_HZ          40000000
`define CSSC_UPD_TMO_MS      100
`define CSSC_UPD_TMO_CYC     ((`CSSC_CLK_HZ / 1000) * `CSSC_UPD_TMO_MS)
`define CSSC_TMO_W           22

`endif

// [design/cssc_pkg.sv]
package cssc_pkg;

    typedef enum logic [1:0] {
        CSSC_FSEL_INT   = 2'b00,
        CSSC_FSEL_CLAMP = 2'b01,
        CSSC_FSEL_HOLD  = 2'b10,
        CSSC_FSEL_PIX   = 2'b11
    } cssc_fsel_t;

    typedef enum logic [1:0] {
        CSSC_ST_IDLE  = 2'b00,
        CSSC_ST_WAIT  = 2'b01,
        CSSC_ST_CLAMP = 2'b10
    } cssc_state_t;

    typedef struct packed {
        logic dc_restore;
        logic black_start;
        logic offset_load;
    } cssc_evt_t;

endpackage

// [design/cssc_clamp_source_select.sv]
// Notes on behaviour
// - clock invert pin used unless bit3 forces low
// - bits 5:4 route aux: clamp, hold, external_pixel_clock
// - clamp pulse triggers dc restore if enabled
// - clamp pulse starts black level if enabled
// - every clamp pulse loads offset dac always
// - internal mode makes clamp each line itself when clamp width is at least 2
// - external clamp: offset changes at leading edge
// - no clamp: offset update within 100ms
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "cssc_defines.svh"

module cssc_clamp_source_select
    import cssc_pkg::*;
#(
    parameter logic [`CSSC_TMO_W-1:0] TMO_CYC =
        `CSSC_TMO_W'(`CSSC_UPD_TMO_CYC)
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    resetn_i,
    input  wire logic [`CSSC_ADDR_W-1:0] addr_i,
    input  wire logic [`CSSC_DATA_W-1:0] wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [`CSSC_DATA_W-1:0] rdata_o,
    input  wire logic                    hsync_i,
    input  wire logic                    aux_i,
    input  wire logic                    clock_invert_input_i,
    output logic                         clk_invert_o,
    output logic                         clamp_o,
    output cssc_evt_t                    clamp_evt_o,
    output logic      [`CSSC_DATA_W-1:0] offset_dac_o,
    output logic                         pll_hold_input_o,
    output logic                         external_pixel_clock_o,
    output logic                         ext_external_pixel_clock_sel_o
);

    logic [7:0]       pll_misc_ff;
    logic [7:0]       start_hi_ff;
    logic [7:0]       start_lo_ff;
    logic [7:0]       clamp_w_ff;
    logic [7:0]       blc_cfg_ff;
    logic [7:0]       dcr_ctrl_ff;
    logic [7:0]       offset_ff;
    logic [7:0]       rdata_ff;
    logic             hs_s1_ff;
    logic             hs_s2_ff;
    logic             hs_d_ff;
    logic             aux_s1_ff;
    logic             aux_s2_ff;
    logic             aux_d_ff;
    logic             ci_s1_ff;
    logic             ci_s2_ff;
    cssc_state_t      state_ff;
    cssc_state_t      nxt_state;
    logic [12:0]      cnt_ff;
    logic [12:0]      nxt_cnt;
    logic             pending_ff;
    logic [`CSSC_TMO_W-1:0] tmo_ff;
    logic             clk_inv_ff;
    logic             clamp_ff;
    cssc_evt_t        evt_ff;
    logic [7:0]       dac_ff;
    logic             hold_ff;
    logic             pix_ff;
    logic             pix_sel_ff;

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_i && (addr_i == ofs);
    endfunction

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur && !prev;
    endfunction

    // register decode and readback
    wire cssc_fsel_t  fsel       = cssc_fsel_t'(
        pll_misc_ff[`CSSC_FSEL_HI:`CSSC_FSEL_LO]);
    wire logic        cinv_dis   = pll_misc_ff[`CSSC_BIT_CINV_DIS];
    wire logic        blc_dis    = blc_cfg_ff[`CSSC_BIT_BLC_DIS];
    wire logic        dcr_en     = dcr_ctrl_ff[`CSSC_BIT_DCR_EN];
    wire logic [12:0] start_pix  = {start_hi_ff[`CSSC_START_HI_W-1:0],
                                    start_lo_ff};
    wire logic        width_ok   = clamp_w_ff >= `CSSC_CLAMP_MIN_W;
    wire logic        wr_offset  = wr_hit(`CSSC_OFS_OFFSET);

    logic [7:0] rd_mux;
    always_comb begin
        case (addr_i)
            `CSSC_OFS_PLL_MISC: rd_mux = pll_misc_ff;
            `CSSC_OFS_START_HI: rd_mux = start_hi_ff;
            `CSSC_OFS_START_LO: rd_mux = start_lo_ff;
            `CSSC_OFS_CLAMP_W:  rd_mux = clamp_w_ff;
            `CSSC_OFS_BLC_CFG:  rd_mux = blc_cfg_ff;
            `CSSC_OFS_DCR_CTRL: rd_mux = dcr_ctrl_ff;
            `CSSC_OFS_OFFSET:   rd_mux = offset_ff;
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_misc_ff <= `CSSC_RST_PLL_MISC;
            start_hi_ff <= `CSSC_RST_START_HI;
            start_lo_ff <= `CSSC_RST_START_LO;
            clamp_w_ff  <= `CSSC_RST_CLAMP_W;
            blc_cfg_ff  <= `CSSC_RST_BLC_CFG;
            dcr_ctrl_ff <= `CSSC_RST_DCR_CTRL;
            offset_ff   <= `CSSC_RST_OFFSET;
            rdata_ff    <= 8'h00;
        end else begin
            if (wr_hit(`CSSC_OFS_PLL_MISC)) pll_misc_ff <= wdata_i;
            if (wr_hit(`CSSC_OFS_START_HI)) start_hi_ff <= wdata_i;
            if (wr_hit(`CSSC_OFS_START_LO)) start_lo_ff <= wdata_i;
            if (wr_hit(`CSSC_OFS_CLAMP_W))  clamp_w_ff  <= wdata_i;
            if (wr_hit(`CSSC_OFS_BLC_CFG))  blc_cfg_ff  <= wdata_i;
            if (wr_hit(`CSSC_OFS_DCR_CTRL)) dcr_ctrl_ff <= wdata_i;
            if (wr_offset)                  offset_ff   <= wdata_i;
            rdata_ff <= rd_i ? rd_mux : 8'h00;
        end
    end

    // pin synchronisers and edge history
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hs_s1_ff  <= 1'b0;
            hs_s2_ff  <= 1'b0;
            hs_d_ff   <= 1'b0;
            aux_s1_ff <= 1'b0;
            aux_s2_ff <= 1'b0;
            aux_d_ff  <= 1'b0;
            ci_s1_ff  <= 1'b0;
            ci_s2_ff  <= 1'b0;
        end else begin
            hs_s1_ff  <= hsync_i;
            hs_s2_ff  <= hs_s1_ff;
            hs_d_ff   <= hs_s2_ff;
            aux_s1_ff <= aux_i;
            aux_s2_ff <= aux_s1_ff;
            aux_d_ff  <= aux_s2_ff;
            ci_s1_ff  <= clock_invert_input_i;
            ci_s2_ff  <= ci_s1_ff;
        end
    end

    // internal clamp generator, one pulse per line
    wire logic hs_trail  = rise(hs_d_ff, hs_s2_ff);
    wire logic int_start = (state_ff == CSSC_ST_WAIT) &&
                           (cnt_ff == start_pix) && width_ok;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 13'h0001;
        case (state_ff)
            CSSC_ST_IDLE: begin
                nxt_cnt = 13'h0000;
            end
            CSSC_ST_WAIT: begin
                if (cnt_ff == start_pix) begin
                    nxt_cnt   = 13'h0000;
                    nxt_state = width_ok ? CSSC_ST_CLAMP : CSSC_ST_IDLE;
                end
            end
            CSSC_ST_CLAMP: begin
                if (cnt_ff == {5'h00, clamp_w_ff} - 13'h0001) begin
                    nxt_state = CSSC_ST_IDLE;
                end
            end
            default: begin
                nxt_state = CSSC_ST_IDLE;
            end
        endcase
        if (hs_trail) begin
            nxt_state = CSSC_ST_WAIT;
            nxt_cnt   = 13'h0000;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= CSSC_ST_IDLE;
            cnt_ff   <= 13'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // source routing and clamp events
    wire logic mode_int   = fsel == CSSC_FSEL_INT;
    wire logic mode_ext   = fsel == CSSC_FSEL_CLAMP;
    wire logic ext_rise   = mode_ext && rise(aux_s2_ff, aux_d_ff);
    wire logic clamp_rise = (mode_int && int_start) || ext_rise;
    wire logic clamp_lvl  = mode_int ? (state_ff == CSSC_ST_CLAMP) :
                            (mode_ext && aux_s2_ff);
    wire logic tmo_hit    = pending_ff && !mode_ext &&
                            (tmo_ff == TMO_CYC - 1'b1);
    wire logic load_now   = clamp_rise || tmo_hit;
    wire cssc_evt_t nxt_evt = '{dc_restore:  clamp_rise && dcr_en,
                                black_start: clamp_rise && !blc_dis,
                                offset_load: load_now};

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending_ff <= 1'b0;
            tmo_ff     <= '0;
        end else begin
            pending_ff <= wr_offset || (pending_ff && !load_now);
            tmo_ff     <= (wr_offset || load_now || mode_ext) ? '0 :
                          (pending_ff ? tmo_ff + 1'b1 : '0);
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clk_inv_ff <= 1'b0;
            clamp_ff   <= 1'b0;
            evt_ff     <= '0;
            dac_ff     <= `CSSC_RST_OFFSET;
            hold_ff    <= 1'b0;
            pix_ff     <= 1'b0;
            pix_sel_ff <= 1'b0;
        end else begin
            clk_inv_ff <= ci_s2_ff && !cinv_dis;
            clamp_ff   <= clamp_lvl;
            evt_ff     <= nxt_evt;
            if (load_now) dac_ff <= offset_ff;
            hold_ff    <= (fsel == CSSC_FSEL_HOLD) && aux_s2_ff;
            pix_ff     <= (fsel == CSSC_FSEL_PIX) && aux_s2_ff;
            pix_sel_ff <= fsel == CSSC_FSEL_PIX;
        end
    end

    assign rdata_o                = rdata_ff;
    assign clk_invert_o           = clk_inv_ff;
    assign clamp_o                = clamp_ff;
    assign clamp_evt_o            = evt_ff;
    assign offset_dac_o           = dac_ff;
    assign pll_hold_input_o       = hold_ff;
    assign external_pixel_clock_o = pix_ff;
    assign ext_external_pixel_clock_sel_o       = pix_sel_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence ext_edge_s;
        mode_ext && aux_s2_ff && !aux_d_ff;
    endsequence

    sequence offset_moved_s;
        ##1 evt_ff.offset_load && dac_ff == $past(offset_ff);
    endsequence

    cinv_forced_low_a: assert property (
        cinv_dis |=> !clk_invert_o)
        else $error("clock invert output not forced low");

    cinv_follows_a: assert property (
        !cinv_dis && ci_s2_ff |=> clk_invert_o)
        else $error("clock invert output ignores pin");

    hold_route_a: assert property (
        (fsel != CSSC_FSEL_HOLD) |=> !pll_hold_input_o)
        else $error("pll hold driven in wrong mode");

    dcr_gate_a: assert property (
        clamp_evt_o.dc_restore |-> $past(dcr_en) && clamp_evt_o.offset_load)
        else $error("dc restore without enabled clamp");

    blc_gate_a: assert property (
        clamp_rise && !blc_dis |=> clamp_evt_o.black_start)
        else $error("black level start missed");

    offset_load_a: assert property (
        clamp_rise |-> offset_moved_s)
        else $error("offset dac not loaded on clamp");

    ext_edge_only_a: assert property (
        mode_ext && $past(mode_ext) && $changed(dac_ff) |->
            $past(ext_rise))
        else $error("offset dac changed off clamp edge");

    ext_load_a: assert property (
        ext_edge_s |=> clamp_evt_o.offset_load &&
            (offset_dac_o == $past(offset_ff)))
        else $error("external clamp edge did not load dac");

    int_clamp_a: assert property (
        mode_int && int_start |=> ##1 clamp_o)
        else $error("internal clamp pulse missing");

    tmo_bound_a: assert property (
        tmo_ff < TMO_CYC)
        else $error("update timeout overran");
endmodule

// [test/cssc_video_src.sv]
`timescale 1ns/1ps

module cssc_video_src (
    input  wire logic ref_clk_i,
    output logic      hsync_o,
    output logic      aux_o
);
    initial begin
        hsync_o = 1'b0;
        aux_o   = 1'b0;
    end

    // one line sync pulse, trailing edge starts the line
    task automatic line();
        @(posedge ref_clk_i);
        hsync_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        hsync_o <= 1'b0;
    endtask

    // aux level: clamp, hold or pixel clock source
    task automatic set_aux(input logic v);
        @(posedge ref_clk_i);
        aux_o <= v;
    endtask
endmodule

// [test/test_clamp_source_select_control.sv]
`timescale 1ns/1ps
`include "cssc_defines.svh"

module test_clamp_source_select_control;
    import cssc_pkg::*;
    logic            ref_clk_i = 1'b0;
    logic            resetn_i  = 1'b0;
    logic [7:0]      addr_i    = 8'h00;
    logic [7:0]      wdata_i   = 8'h00;
    logic            wr_i      = 1'b0;
    logic            rd_i      = 1'b0;
    logic            cinv_pin  = 1'b1;
    logic [7:0]      rdata_o;
    logic            hsync;
    logic            aux;
    logic            clk_invert_o;
    logic            clamp_o;
    cssc_evt_t       clamp_evt_o;
    logic [7:0]      offset_dac_o;
    logic            pll_hold_input_o;
    logic            external_pixel_clock_o;
    logic            ext_external_pixel_clock_sel_o;
    int              num_errors = 0;
    int              num_checks = 0;
    int              cyc = 0;
    logic [7:0]      d;
    localparam logic [7:0] ROW_A [8] = '{8'h13, 8'h14, 8'h15, 8'h16,
                                         8'h17, 8'h18, 8'h19, 8'h20};
    localparam logic [7:0] ROW_R [8] = '{8'h04, 8'h00, 8'h03, 8'h10,
                                         8'h40, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ROW_W [8] = '{8'h08, 8'h1f, 8'h04, 8'h03,
                                         8'h41, 8'h01, 8'h5a, 8'h77};
    localparam logic [7:0] ROW_B [8] = '{8'h08, 8'h1f, 8'h04, 8'h03,
                                         8'h41, 8'h01, 8'h5a, 8'h00};

    always #12.5 ref_clk_i = ~ref_clk_i;

    cssc_video_src src_u (
        .ref_clk_i (ref_clk_i),
        .hsync_o   (hsync),
        .aux_o     (aux)
    );

    cssc_clamp_source_select #(.TMO_CYC(22'h32)) dut_u (
        .ref_clk_i              (ref_clk_i),
        .resetn_i               (resetn_i),
        .addr_i                 (addr_i),
        .wdata_i                (wdata_i),
        .wr_i                   (wr_i),
        .rd_i                   (rd_i),
        .rdata_o                (rdata_o),
        .hsync_i                (hsync),
        .aux_i                  (aux),
        .clock_invert_input_i   (cinv_pin),
        .clk_invert_o           (clk_invert_o),
        .clamp_o                (clamp_o),
        .clamp_evt_o            (clamp_evt_o),
        .offset_dac_o           (offset_dac_o),
        .pll_hold_input_o       (pll_hold_input_o),
        .external_pixel_clock_o (external_pixel_clock_o),
        .ext_external_pixel_clock_sel_o       (ext_external_pixel_clock_sel_o)
    );

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask

    // wait for an offset load pulse, then leave the event checked
    task automatic wait_load(input logic [2:0] e, input logic [7:0] o);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 80 && !hit; i++) begin
            @(posedge ref_clk_i);
            #1 hit = (clamp_evt_o.offset_load === 1'b1);
        end
        chk({7'h00, hit}, 8'h01);
        chk({5'h00, clamp_evt_o}, {5'h00, e});
        chk(offset_dac_o, o);
    endtask

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(ROW_A[i], d);
            chk(d, ROW_R[i]);
            wr(ROW_A[i], ROW_W[i]);
            rd(ROW_A[i], d);
            chk(d, ROW_B[i]);
        end
        $display("register table done");
        wr(8'h14, 8'h00);
        repeat (4) @(posedge ref_clk_i);
        chk({7'h00, clk_invert_o}, 8'h00);
        wr(8'h13, 8'h00);
        repeat (5) @(posedge ref_clk_i);
        chk({7'h00, clk_invert_o}, 8'h01);
        $display("clock invert done");
        wr(8'h19, 8'h3c);
        wait_load(3'b001, 8'h3c);
        $display("timeout load done");
        wr(8'h17, 8'h40);
        src_u.line();
        wait_load(3'b111, 8'h3c);
        @(posedge ref_clk_i);
        #1 chk({7'h00, clamp_o}, 8'h01);
        repeat (3) @(posedge ref_clk_i);
        #1 chk({7'h00, clamp_o}, 8'h00);
        $display("internal clamp done");
        wr(8'h13, 8'h10);
        wr(8'h19, 8'ha5);
        wr(8'h17, 8'h41);
        wr(8'h18, 8'h00);
        repeat (60) @(posedge ref_clk_i);
        chk(offset_dac_o, 8'h3c);
        src_u.set_aux(1'b1);
        wait_load(3'b001, 8'ha5);
        chk({7'h00, clamp_o}, 8'h01);
        src_u.set_aux(1'b0);
        $display("external clamp done");
        wr(8'h13, 8'h20);
        src_u.set_aux(1'b1);
        repeat (5) @(posedge ref_clk_i);
        chk({6'h00, ext_external_pixel_clock_sel_o, pll_hold_input_o}, 8'h01);
        wr(8'h13, 8'h30);
        repeat (3) @(posedge ref_clk_i);
        chk({6'h00, ext_external_pixel_clock_sel_o, external_pixel_clock_o}, 8'h03);
        $display("hold and pixel clock done");
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk(offset_dac_o, 8'h00);
        resetn_i <= 1'b1;
        rd(8'h13, d);
        chk(d, 8'h04);
        $display("second reset done");
        wrap_up();
    end
endmodule
